// >>> rtl/compact_timer_pkg.sv
// constants, register map and field layouts of the compact 10-bit timer
package compact_timer_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFF_CTRL0   = 8'h00;
  localparam logic [7:0] OFF_CTRL1   = 8'h04;
  localparam logic [7:0] OFF_CNT_LO  = 8'h08;
  localparam logic [7:0] OFF_CNT_HI  = 8'h0c;
  localparam logic [7:0] OFF_CMPA_LO = 8'h10;
  localparam logic [7:0] OFF_CMPA_HI = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [9:0] CNT_RST  = 10'h000;

  // status bit positions (write one to clear)
  localparam int ST_A_BIT = 0;
  localparam int ST_P_BIT = 1;

  // operating modes
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TC  = 2'h3;

  // pin function codes, compare-match meaning
  localparam logic [1:0] FN_LOW    = 2'h1;
  localparam logic [1:0] FN_HIGH   = 2'h2;
  localparam logic [1:0] FN_TOGGLE = 2'h3;
  // pin function codes, pwm meaning
  localparam logic [1:0] FN_PWM_INACT = 2'h0;
  localparam logic [1:0] FN_PWM_ACT   = 2'h1;
  localparam logic [1:0] FN_PWM_WAVE  = 2'h2;

  // count clock selections
  localparam logic [2:0] CK_SYS4     = 3'h0;
  localparam logic [2:0] CK_SYS      = 3'h1;
  localparam logic [2:0] CK_H16      = 3'h2;
  localparam logic [2:0] CK_H64      = 3'h3;
  localparam logic [2:0] CK_SUB_A    = 3'h4;
  localparam logic [2:0] CK_SUB_B    = 3'h5;
  localparam logic [2:0] CK_EXT_RISE = 3'h6;

  // prescaler terminal counts
  localparam logic [1:0] DIV4_LAST  = 2'h3;
  localparam logic [3:0] DIV16_LAST = 4'hf;
  localparam logic [5:0] DIV64_LAST = 6'h3f;

  // full-range period when the period comparator is zero
  localparam logic [10:0] FULL_SPAN = 11'h400;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       counter_pause;
    logic [2:0] count_clock_select;
    logic       timer_on;
    logic [2:0] period_compare_value;
  } ctrl0_t;

  typedef struct packed {
    logic [1:0] operating_mode_select;
    logic [1:0] output_pin_function;
    logic       output_initial_level;
    logic       output_polarity_invert;
    logic       period_duty_swap;
    logic       counter_clear_select;
  } ctrl1_t;
endpackage

// >>> rtl/compact_timer_pwm_regs.sv
// compact 10-bit timer with compare, pwm and counter modes behind an axi4-lite slave
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.

// How it works
// - pause bit freezes counter, resumes from value
// - 3-bit field selects count clock source
// - counting only while on bit set
// - on bit rising edge clears counter
// - on bit rising edge restores initial pin level outside counter mode
// - period value matches counter bits 9..7
// - zero period value means 1024-count overflow
// - 2-bit field picks compare, pwm, counter
// - compare A match drives pin per function
// - match to current level leaves pin unchanged
// - pwm pin: inactive, active or waveform
// - initial level bit: start level, pwm active
// - polarity bit inverts the output pin
// - swap bit exchanges pwm period and duty
// - clear select: compare A or period match
// - clear select ignored in pwm mode
// - counter mode leaves the pin alone
// - counter readable as low/high byte pair
// - compare A held as low/high byte pair
// - low bytes pass through 8-bit buffer
// - separate flags for compare A, period match
module compact_timer_pwm_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  input  wire logic              sub_clock_tick_in,
  input  wire logic              external_count_input_in,
  output logic                   timer_output_pin_out,
  output logic                   timer_output_inverted_out,
  output logic                   compare_a_flag_out,
  output logic                   period_match_flag_out
);

  compact_timer_pkg::ctrl0_t c0_r;
  compact_timer_pkg::ctrl1_t c1_r;
  logic [9:0]        cnt_r;
  logic [9:0]        cmpa_r;
  logic [7:0]        buf_r;
  logic              on_prev_r;
  logic              ext_prev_r;
  logic [5:0]        presc_r;
  logic              pin_r;
  logic              flag_a_r;
  logic              flag_p_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0]        w_data_r;
  logic              w_lane_r;
  logic              aw_have_r;
  logic              w_have_r;

  // only aligned words at the listed offsets answer OKAY
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = a[7:0];
    is_mapped = ((a >> 8) == '0) &&
      (o == compact_timer_pkg::OFF_CTRL0 || o == compact_timer_pkg::OFF_CTRL1 ||
       o == compact_timer_pkg::OFF_CNT_LO || o == compact_timer_pkg::OFF_CNT_HI ||
       o == compact_timer_pkg::OFF_CMPA_LO || o == compact_timer_pkg::OFF_CMPA_HI ||
       o == compact_timer_pkg::OFF_STATUS);
  endfunction

  // bus handshakes
  logic aw_fire, w_fire, ar_fire, wr_go, b_fire, r_fire;
  assign aw_fire = s_axi_awvalid_in && s_axi_awready_out;
  assign w_fire  = s_axi_wvalid_in && s_axi_wready_out;
  assign ar_fire = s_axi_arvalid_in && s_axi_arready_out;
  assign wr_go   = aw_have_r && w_have_r && !s_axi_bvalid_out;
  assign b_fire  = s_axi_bvalid_out && s_axi_bready_in;
  assign r_fire  = s_axi_rvalid_out && s_axi_rready_in;

  // register writes, only byte lane 0 carries data
  logic wr_en;
  logic [7:0] wr_off;
  assign wr_en  = wr_go && w_lane_r && is_mapped(aw_addr_r);
  assign wr_off = aw_addr_r[7:0];

  // timer state shorthands
  logic on_rise, is_pwm, tick, cnt_step, use_a_clr, p_zero;
  logic [10:0] inc, prd_span, duty_val;
  logic p_hit, a_hit, ovf, clr, a_evt, p_evt, pwm_act;
  assign on_rise = c0_r.timer_on && !on_prev_r;
  assign is_pwm  = c1_r.operating_mode_select == compact_timer_pkg::MODE_PWM;
  assign p_zero  = c0_r.period_compare_value == 3'h0;
  assign inc     = {1'b0, cnt_r} + 11'h001;
  assign ovf     = inc[10];
  assign p_hit   = !p_zero && inc[9:0] == {c0_r.period_compare_value, 7'h00};
  assign a_hit   = cmpa_r != 10'h000 && inc[9:0] == cmpa_r;
  assign use_a_clr = is_pwm ? c1_r.period_duty_swap : c1_r.counter_clear_select;
  assign clr     = ovf || (use_a_clr ? a_hit : p_hit);
  assign cnt_step = c0_r.timer_on && !c0_r.counter_pause && tick && !on_rise;
  assign a_evt   = cnt_step && a_hit;
  // no period flag when compare A clears outside pwm mode
  assign p_evt   = cnt_step && (p_hit || (p_zero && ovf)) &&
                   (is_pwm || !c1_r.counter_clear_select);
  assign prd_span = p_zero ? compact_timer_pkg::FULL_SPAN
                           : {1'b0, c0_r.period_compare_value, 7'h00};
  // duty at or beyond the period gives a constant active level
  assign duty_val = c1_r.period_duty_swap ? prd_span : {1'b0, cmpa_r};
  assign pwm_act  = {1'b0, cnt_r} < duty_val;

  // count clock selection; fH is taken as the system clock here
  always_comb begin
    case (c0_r.count_clock_select)
      compact_timer_pkg::CK_SYS4:     tick = presc_r[1:0] == compact_timer_pkg::DIV4_LAST;
      compact_timer_pkg::CK_SYS:      tick = 1'b1;
      compact_timer_pkg::CK_H16:      tick = presc_r[3:0] == compact_timer_pkg::DIV16_LAST;
      compact_timer_pkg::CK_H64:      tick = presc_r == compact_timer_pkg::DIV64_LAST;
      compact_timer_pkg::CK_SUB_A,
      compact_timer_pkg::CK_SUB_B:    tick = sub_clock_tick_in;
      compact_timer_pkg::CK_EXT_RISE: tick = external_count_input_in && !ext_prev_r;
      default:                        tick = !external_count_input_in && ext_prev_r;
    endcase
  end

  // free prescaler and edge history; prescaler free-runs so pause keeps phase
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      presc_r    <= 6'h00;
      ext_prev_r <= 1'b0;
      on_prev_r  <= 1'b0;
    end else begin
      presc_r    <= presc_r + 6'h01;
      ext_prev_r <= external_count_input_in;
      on_prev_r  <= c0_r.timer_on;
    end
  end

  // the 10-bit up counter
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cnt_r <= compact_timer_pkg::CNT_RST;
    end else if (on_rise) begin
      cnt_r <= compact_timer_pkg::CNT_RST;
    end else if (cnt_step) begin
      cnt_r <= clr ? compact_timer_pkg::CNT_RST : inc[9:0];
    end
  end

  // output pin state before polarity
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_r <= 1'b0;
    end else if (on_rise &&
                 c1_r.operating_mode_select != compact_timer_pkg::MODE_TC) begin
      pin_r <= c1_r.output_initial_level;
    end else if (is_pwm) begin
      case (c1_r.output_pin_function)
        compact_timer_pkg::FN_PWM_INACT: pin_r <= !c1_r.output_initial_level;
        compact_timer_pkg::FN_PWM_ACT:   pin_r <= c1_r.output_initial_level;
        compact_timer_pkg::FN_PWM_WAVE:
          pin_r <= pwm_act ? c1_r.output_initial_level : !c1_r.output_initial_level;
        default:                         pin_r <= pin_r;
      endcase
    end else if (c1_r.operating_mode_select == compact_timer_pkg::MODE_CMP && a_evt) begin
      // forcing the held level is naturally a no-change
      case (c1_r.output_pin_function)
        compact_timer_pkg::FN_LOW:    pin_r <= 1'b0;
        compact_timer_pkg::FN_HIGH:   pin_r <= 1'b1;
        compact_timer_pkg::FN_TOGGLE: pin_r <= !pin_r;
        default:                      pin_r <= pin_r;
      endcase
    end
  end

  // pin pair; counter mode freezes them so the pin is free for other use
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      timer_output_pin_out      <= 1'b0;
      timer_output_inverted_out <= 1'b1;
    end else if (c1_r.operating_mode_select != compact_timer_pkg::MODE_TC) begin
      timer_output_pin_out      <= pin_r ^ c1_r.output_polarity_invert;
      timer_output_inverted_out <= !(pin_r ^ c1_r.output_polarity_invert);
    end
  end

  // sticky match flags, a new event beats a same-cycle clear
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      flag_a_r <= 1'b0;
      flag_p_r <= 1'b0;
    end else begin
      flag_a_r <= (flag_a_r && !(wr_en && wr_off == compact_timer_pkg::OFF_STATUS &&
                   w_data_r[compact_timer_pkg::ST_A_BIT])) || a_evt;
      flag_p_r <= (flag_p_r && !(wr_en && wr_off == compact_timer_pkg::OFF_STATUS &&
                   w_data_r[compact_timer_pkg::ST_P_BIT])) || p_evt;
    end
  end
  assign compare_a_flag_out    = flag_a_r;
  assign period_match_flag_out = flag_p_r;

  // control registers; mode and pin function are not guarded in hardware
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      c0_r <= compact_timer_pkg::CTRL_RST;
      c1_r <= compact_timer_pkg::CTRL_RST;
    end else if (wr_en) begin
      if (wr_off == compact_timer_pkg::OFF_CTRL0) c0_r <= w_data_r;
      if (wr_off == compact_timer_pkg::OFF_CTRL1) c1_r <= w_data_r;
    end
  end

  // compare A pair and shared low-byte buffer
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cmpa_r <= 10'h000;
      buf_r  <= 8'h00;
    end else if (wr_en && wr_off == compact_timer_pkg::OFF_CMPA_LO) begin
      buf_r <= w_data_r;
    end else if (wr_en && wr_off == compact_timer_pkg::OFF_CMPA_HI) begin
      cmpa_r <= {w_data_r[1:0], buf_r};
    end else if (ar_fire && s_axi_araddr_in[7:0] == compact_timer_pkg::OFF_CNT_HI) begin
      buf_r <= cnt_r[7:0];
    end else if (ar_fire && s_axi_araddr_in[7:0] == compact_timer_pkg::OFF_CMPA_HI) begin
      buf_r <= cmpa_r[7:0];
    end
  end

  // write channel: address and data taken in either order
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      aw_have_r         <= 1'b0;
      w_have_r          <= 1'b0;
      aw_addr_r         <= '0;
      w_data_r          <= 8'h00;
      w_lane_r          <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= compact_timer_pkg::RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_addr_r         <= s_axi_awaddr_in;
        aw_have_r         <= 1'b1;
        s_axi_awready_out <= 1'b0;
      end
      if (w_fire) begin
        w_data_r         <= s_axi_wdata_in[7:0];
        w_lane_r         <= s_axi_wstrb_in[0];
        w_have_r         <= 1'b1;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= is_mapped(aw_addr_r) ? compact_timer_pkg::RESP_OKAY
                                                 : compact_timer_pkg::RESP_SLVERR;
        aw_have_r        <= 1'b0;
        w_have_r         <= 1'b0;
      end
      if (b_fire) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // read channel; upper bits of narrow registers read as zero
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= compact_timer_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rresp_out   <= is_mapped(s_axi_araddr_in) ? compact_timer_pkg::RESP_OKAY
                                                      : compact_timer_pkg::RESP_SLVERR;
      case (s_axi_araddr_in[7:0])
        compact_timer_pkg::OFF_CTRL0:   s_axi_rdata_out <= {24'h0, c0_r};
        compact_timer_pkg::OFF_CTRL1:   s_axi_rdata_out <= {24'h0, c1_r};
        compact_timer_pkg::OFF_CNT_LO,
        compact_timer_pkg::OFF_CMPA_LO: s_axi_rdata_out <= {24'h0, buf_r};
        compact_timer_pkg::OFF_CNT_HI:  s_axi_rdata_out <= {30'h0, cnt_r[9:8]};
        compact_timer_pkg::OFF_CMPA_HI: s_axi_rdata_out <= {30'h0, cmpa_r[9:8]};
        compact_timer_pkg::OFF_STATUS:  s_axi_rdata_out <= {30'h0, flag_p_r, flag_a_r};
        default:                        s_axi_rdata_out <= 32'h0000_0000;
      endcase
    end else if (r_fire) begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // checks on the counter, pin and flags
  chk_pause_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    c0_r.timer_on && on_prev_r && c0_r.counter_pause |=> cnt_r == $past(cnt_r))
    else $error("counter moved while paused");
  chk_off_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    !c0_r.timer_on |=> cnt_r == $past(cnt_r))
    else $error("counter moved while off");
  chk_on_clear: assert property (@(posedge clk_in) disable iff (reset_in)
    on_rise |=> cnt_r == 10'h000)
    else $error("counter not cleared on enable");
  chk_pin_initial: assert property (@(posedge clk_in) disable iff (reset_in)
    on_rise && c1_r.operating_mode_select == compact_timer_pkg::MODE_CMP
    |=> pin_r == $past(c1_r.output_initial_level) ##1
        timer_output_pin_out == ($past(pin_r) ^ $past(c1_r.output_polarity_invert)))
    else $error("pin not restored to initial level");
  chk_period_clear: assert property (@(posedge clk_in) disable iff (reset_in)
    cnt_step && !is_pwm && !c1_r.counter_clear_select && !p_zero &&
    cnt_r + 10'h001 == {c0_r.period_compare_value, 7'h00} |=> cnt_r == 10'h000 && flag_p_r)
    else $error("period match did not clear");
  chk_wrap: assert property (@(posedge clk_in) disable iff (reset_in)
    cnt_step && cnt_r == 10'h3ff |=> cnt_r == 10'h000)
    else $error("counter did not wrap");
  chk_increment: assert property (@(posedge clk_in) disable iff (reset_in)
    cnt_step && !clr |=> cnt_r == $past(cnt_r) + 10'h001)
    else $error("counter did not step by one");
  chk_pwm_force: assert property (@(posedge clk_in) disable iff (reset_in)
    is_pwm && !on_rise && c1_r.output_pin_function == compact_timer_pkg::FN_PWM_INACT
    |=> pin_r == !$past(c1_r.output_initial_level))
    else $error("pwm inactive force wrong");
  chk_pin_pair: assert property (@(posedge clk_in) disable iff (reset_in)
    timer_output_inverted_out == !timer_output_pin_out)
    else $error("output pair not complementary");
  chk_a_flag: assert property (@(posedge clk_in) disable iff (reset_in)
    a_evt |=> compare_a_flag_out)
    else $error("compare A flag not raised");
  chk_hi_latch: assert property (@(posedge clk_in) disable iff (reset_in)
    ar_fire && s_axi_araddr_in[7:0] == compact_timer_pkg::OFF_CNT_HI
    |=> buf_r == $past(cnt_r[7:0]) && s_axi_rdata_out[9:0] == 10'h000 + $past(cnt_r[9:8]))
    else $error("high read did not latch low byte");

  // checks on clearing, flag rules, the pwm active force and the frozen pin in counter mode
  chk_tc_freeze: assert property (@(posedge clk_in) disable iff (reset_in)
    c1_r.operating_mode_select == compact_timer_pkg::MODE_TC
    |=> $stable(timer_output_pin_out))
    else $error("pin moved in counter mode");
  chk_a_clear: assert property (@(posedge clk_in) disable iff (reset_in)
    cnt_step && !is_pwm && c1_r.counter_clear_select && a_hit
    |=> cnt_r == 10'h000 && flag_a_r)
    else $error("compare A match did not clear");
  chk_no_p_flag: assert property (@(posedge clk_in) disable iff (reset_in)
    !is_pwm && c1_r.counter_clear_select && !flag_p_r |=> !flag_p_r)
    else $error("period flag set with compare A clearing");
  chk_ovf_flag: assert property (@(posedge clk_in) disable iff (reset_in)
    cnt_step && p_zero && !c1_r.counter_clear_select && cnt_r == 10'h3ff
    |=> flag_p_r)
    else $error("overflow did not flag");
  chk_flag_clear: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_en && wr_off == compact_timer_pkg::OFF_STATUS &&
    w_data_r[compact_timer_pkg::ST_A_BIT] && !a_evt |=> !flag_a_r)
    else $error("compare A flag not cleared");
  chk_pwm_active: assert property (@(posedge clk_in) disable iff (reset_in)
    is_pwm && !on_rise && c1_r.output_pin_function == compact_timer_pkg::FN_PWM_ACT
    |=> pin_r == $past(c1_r.output_initial_level))
    else $error("pwm active force wrong");

endmodule

// >>> sim/compact_timer_pwm_regs_bench.sv
// self-checking bench for the compact 10-bit timer register block
module compact_timer_pwm_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_in   = 1'b0;
  logic        reset_in = 1'b1;
  logic [7:0]  awaddr   = 8'h00;
  logic        awvalid  = 1'b0;
  logic        awready;
  logic [31:0] wdata    = 32'h0;
  logic [3:0]  wstrb    = 4'h0;
  logic        wvalid   = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready   = 1'b0;
  logic [7:0]  araddr   = 8'h00;
  logic        arvalid  = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready   = 1'b0;
  logic        sub_tick = 1'b0;
  logic        ext_in   = 1'b0;
  logic        pin;
  logic        pin_n;
  logic        flag_a;
  logic        flag_p;
  int          failures = 0;
  int          checks   = 0;

  // 100 mhz system clock
  always #5 clk_in = ~clk_in;

  compact_timer_pwm_regs compact_timer_pwm_regs_i (
    .clk_in(clk_in), .reset_in(reset_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .sub_clock_tick_in(sub_tick),
    .external_count_input_in(ext_in), .timer_output_pin_out(pin),
    .timer_output_inverted_out(pin_n), .compare_a_flag_out(flag_a),
    .period_match_flag_out(flag_p)
  );

  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // a bounded wait that runs out ends the run here
  task automatic hang(input string what);
    failures++;
    $display("unexpected at %0t: no %s response", $time, what);
    finish_test();
  endtask

  // aw and w offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                    output logic [1:0] resp);
    logic b_ok;
    b_ok = 1'b0;
    @(posedge clk_in);
    awaddr <= a; wdata <= {24'h0, d}; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int n = 0; n < 40 && !b_ok; n++) begin
      @(posedge clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        b_ok = 1'b1; resp = bresp; bready <= 1'b0;
      end
    end
    if (!b_ok) hang("write");
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic r_ok;
    r_ok = 1'b0;
    @(posedge clk_in);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int n = 0; n < 40 && !r_ok; n++) begin
      @(posedge clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        r_ok = 1'b1; d = rdata; resp = rresp; rready <= 1'b0;
      end
    end
    if (!r_ok) hang("read");
  endtask

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, 4'h1, r);
    chk(r, compact_timer_pkg::RESP_OKAY, "write resp");
  endtask

  task automatic get(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    rd(a, d, r);
  endtask

  // high byte first so the low byte comes from the same snapshot
  task automatic read_count(output logic [9:0] v);
    logic [31:0] hi, lo;
    get(compact_timer_pkg::OFF_CNT_HI, hi);
    get(compact_timer_pkg::OFF_CNT_LO, lo);
    v = {hi[1:0], lo[7:0]};
  endtask

  task automatic test_regs;
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 6; i++) begin
      get(8'(4 * i), d);
      chk(d, 32'h0, "reset value");
    end
    put(compact_timer_pkg::OFF_CNT_HI, 8'hff);
    get(compact_timer_pkg::OFF_CNT_HI, d);
    chk(d, 32'h0, "counter not writable");
    rd(8'h1c, d, r);
    chk({d[29:0], r}, {30'h0, compact_timer_pkg::RESP_SLVERR}, "unmapped");
    put(compact_timer_pkg::OFF_CMPA_LO, 8'ha5);
    put(compact_timer_pkg::OFF_CMPA_HI, 8'hfe);
    wr(compact_timer_pkg::OFF_CMPA_HI, 8'h01, 4'h0, r);
    chk(r, compact_timer_pkg::RESP_OKAY, "masked write resp");
    get(compact_timer_pkg::OFF_CMPA_HI, d);
    chk(d, 32'h2, "compare high");
    get(compact_timer_pkg::OFF_CMPA_LO, d);
    chk(d, 32'ha5, "compare low via buffer");
    $display("test_regs done");
  endtask

  // each source gets five pulses on both the pin and the sub tick
  task automatic test_clocks;
    logic [9:0] v;
    logic [2:0] codes[4] = '{3'h6, 3'h7, 3'h4, 3'h5};
    logic [2:0] pcodes[3] = '{3'h0, 3'h2, 3'h3};
    int         divs[3] = '{4, 16, 64};
    put(compact_timer_pkg::OFF_CTRL1, 8'hc0);
    foreach (codes[k]) begin
      put(compact_timer_pkg::OFF_CTRL0, {1'b0, codes[k], 4'h0});
      put(compact_timer_pkg::OFF_CTRL0, {1'b0, codes[k], 4'h8});
      repeat (5) begin
        @(posedge clk_in); ext_in <= 1'b1; sub_tick <= 1'b1;
        @(posedge clk_in); sub_tick <= 1'b0;
        @(posedge clk_in); ext_in <= 1'b0;
        @(posedge clk_in);
      end
      repeat (3) @(posedge clk_in);
      read_count(v);
      chk(v, 32'd5, "source count");
    end
    // prescaler phase is free, so one extra tick is allowed
    foreach (pcodes[k]) begin
      put(compact_timer_pkg::OFF_CTRL0, {1'b0, pcodes[k], 4'h0});
      put(compact_timer_pkg::OFF_CTRL0, {1'b0, pcodes[k], 4'h8});
      repeat (640) @(posedge clk_in);
      read_count(v);
      chk(v >= 640 / divs[k] && v <= 640 / divs[k] + 1, 1, "prescaled count");
    end
    $display("test_clocks done");
  endtask

  task automatic test_pause;
    logic [9:0] v1, v2;
    put(compact_timer_pkg::OFF_CTRL0, 8'h10);
    put(compact_timer_pkg::OFF_CTRL0, 8'h98);
    read_count(v1);
    chk(v1, 32'h0, "cleared on enable");
    put(compact_timer_pkg::OFF_CTRL0, 8'h18);
    repeat (20) @(posedge clk_in);
    put(compact_timer_pkg::OFF_CTRL0, 8'h98);
    read_count(v1);
    repeat (10) @(posedge clk_in);
    read_count(v2);
    chk({v1 == 10'h0, v2}, {1'b0, v1}, "paused hold");
    put(compact_timer_pkg::OFF_CTRL0, 8'h18);
    read_count(v2);
    chk(v2 > v1 && v2 < v1 + 10'd40, 1, "resume from held");
    put(compact_timer_pkg::OFF_CTRL0, 8'h10);
    read_count(v1);
    repeat (10) @(posedge clk_in);
    read_count(v2);
    chk(v2, v1, "off keeps value");
    $display("test_pause done");
  endtask

  task automatic test_clear;
    logic [9:0] v;
    put(compact_timer_pkg::OFF_STATUS, 8'h03);
    put(compact_timer_pkg::OFF_CTRL0, 8'h19);
    repeat (100) @(posedge clk_in);
    chk(flag_p, 1'b0, "period flag early");
    repeat (60) @(posedge clk_in);
    read_count(v);
    chk({flag_p, flag_a, v[9:7]}, 5'b10000, "period match");
    put(compact_timer_pkg::OFF_CTRL0, 8'h11);
    put(compact_timer_pkg::OFF_CTRL1, 8'hc1);
    put(compact_timer_pkg::OFF_CMPA_LO, 8'h40);
    put(compact_timer_pkg::OFF_CMPA_HI, 8'h00);
    put(compact_timer_pkg::OFF_STATUS, 8'h03);
    put(compact_timer_pkg::OFF_CTRL0, 8'h19);
    repeat (200) @(posedge clk_in);
    read_count(v);
    chk({flag_p, flag_a, v < 10'd64}, 3'b011, "compare a clear");
    put(compact_timer_pkg::OFF_CTRL0, 8'h10);
    put(compact_timer_pkg::OFF_CTRL1, 8'hc0);
    put(compact_timer_pkg::OFF_STATUS, 8'h03);
    put(compact_timer_pkg::OFF_CTRL0, 8'h18);
    repeat (1000) @(posedge clk_in);
    chk(flag_p, 1'b0, "overflow flag early");
    repeat (40) @(posedge clk_in);
    read_count(v);
    chk({flag_p, flag_a, v < 10'd64}, 3'b111, "overflow wrap");
    $display("test_clear done");
  endtask

  // pin sampled just after enable and again after the first match
  task automatic run_cmp(input logic [7:0] c1, input logic a, input logic b);
    put(compact_timer_pkg::OFF_CTRL0, 8'h11);
    put(compact_timer_pkg::OFF_CTRL1, c1);
    put(compact_timer_pkg::OFF_CTRL0, 8'h19);
    repeat (5) @(posedge clk_in);
    chk({pin, pin_n}, {a, ~a}, "pin after enable");
    repeat (90) @(posedge clk_in);
    chk({pin, pin_n}, {b, ~b}, "pin after match");
  endtask

  // high cycles over two full 128-count periods
  task automatic run_pwm(input logic [7:0] c1, input int exp);
    int n;
    n = 0;
    put(compact_timer_pkg::OFF_CTRL0, 8'h11);
    put(compact_timer_pkg::OFF_CTRL1, c1);
    put(compact_timer_pkg::OFF_CTRL0, 8'h19);
    repeat (10) @(posedge clk_in);
    repeat (256) begin
      @(posedge clk_in);
      if (pin === 1'b1) n++;
    end
    chk(n, exp, "pwm high cycles");
  endtask

  initial begin
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    test_regs();
    test_clocks();
    test_pause();
    test_clear();
    run_cmp(8'h21, 1'b0, 1'b1);
    run_cmp(8'h25, 1'b1, 1'b0);
    run_cmp(8'h29, 1'b1, 1'b1);
    run_cmp(8'h19, 1'b1, 1'b0);
    run_cmp(8'h09, 1'b1, 1'b1);
    run_cmp(8'h31, 1'b0, 1'b1);
    $display("compare output done");
    run_pwm(8'ha8, 128);
    run_pwm(8'haa, 256);
    run_pwm(8'ha9, 128);
    run_pwm(8'h98, 256);
    run_pwm(8'h88, 0);
    run_pwm(8'h90, 0);
    $display("pwm done");
    finish_test();
  end
endmodule
